// ---- rtl/stop_ctrl_pkg.sv ----
// Package: register map, field layouts, reset values and timing counts for the stop controller
package stop_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] CFG_OFF = 8'h00;
   localparam logic [7:0] HOLD_OFF = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   localparam logic [7:0] IRQ_OFF = 8'h0C;
   localparam logic [7:0] MASK_OFF = 8'h10;
   localparam logic [7:0] CMD_OFF = 8'h14;
   // Configuration field positions
   localparam int CFG_STOP_LSB = 0;
   localparam int CFG_GRP2_BIT = 4;
   localparam int CFG_MODE_LSB = 8;
   // Stop-method encodings
   localparam logic [1:0] STOP_DB_HOLD = 2'h0;
   localparam logic [1:0] STOP_DB_COAST = 2'h1;
   localparam logic [1:0] STOP_COAST = 2'h2;
   // Control modes
   localparam logic [1:0] MODE_POS = 2'h0;
   localparam logic [1:0] MODE_SPEED = 2'h1;
   localparam logic [1:0] MODE_TORQUE = 2'h2;
   // Hold time limits in ms
   localparam logic [9:0] HOLD_MIN = 10'h014;
   localparam logic [9:0] HOLD_MAX = 10'h3E8;
   localparam logic [9:0] HOLD_RST = 10'h014;
   // Timing: 1 ms tick at 100 MHz
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
   // Interrupt bits
   localparam int IRQ_CUT = 0;
   localparam int IRQ_OFFPOW = 1;
   localparam int IRQ_STOPPED = 2;
   localparam int IRQ_W = 3;
   // Output stop drive states
   typedef enum logic [3:0]
   {
      ST_RUN = 4'b0001,
      ST_DB = 4'b0010,
      ST_ZSTOP = 4'b0100,
      ST_COAST = 4'b1000
   } stop_state_t;
endpackage : stop_ctrl_pkg

// ---- rtl/ms_ticker.sv ----
// Millisecond tick divider producing a one-cycle enable
`timescale 1ns/10ps
`default_nettype none
module ms_ticker
   import stop_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);
   typedef struct packed
   {
      logic [16:0] cnt;
      logic tick;
   } tick_state_t;
   tick_state_t s_reg;
   tick_state_t s_next;
   localparam logic [16:0] TOP = 17'(TICK_CYC - 1);

   // Count to one millisecond and pulse
   always_comb
   begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.cnt == TOP)
      begin
         s_next.cnt = 17'h00000;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 17'h00001;
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end
   assign tick = s_reg.tick;
endmodule : ms_ticker
`default_nettype wire

// ---- rtl/stop_ctrl.sv ----
// Servo stop-method selection and power-cut hold controller with APB registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module stop_ctrl
   import stop_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic servo_off_command,
   input wire logic alarm_group_one,
   input wire logic alarm_group_two,
   input wire logic main_power_ok,
   input wire logic motor_stopped,
   input wire logic low_speed,
   output logic motor_power_on,
   output logic dynamic_brake,
   output logic zero_speed_stop,
   output logic power_cut_flag,
   output logic irq
);
   import stop_ctrl_pkg::*;

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed
   {
      logic [1:0] stop_sel_wr;
      logic grp2_sel_wr;
      logic [1:0] ctrl_mode;
      logic [1:0] stop_method_select;
      logic group_two_alarm_stop_select;
      logic [9:0] power_cut_hold_time;
      logic [9:0] cut_ms;
      logic cutting;
      logic cut_expired;
      logic after_db_coast;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      stop_state_t st;
      logic started;
   } ctrl_state_t;

   ctrl_state_t s_reg;
   ctrl_state_t s_next;
   logic tick;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic stop_req;
   logic use_zero;
   logic [IRQ_W-1:0] ev;

   ms_ticker u_tick
   (
      .clk(clk),
      .nrst(nrst),
      .tick(tick)
   );

   // ----------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------
   // Zero-wait slave; error on unmapped address
   assign addr_ok = (paddr == CFG_OFF) || (paddr == HOLD_OFF) || (paddr == STAT_OFF)
                 || (paddr == IRQ_OFF) || (paddr == MASK_OFF) || (paddr == CMD_OFF);
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Stop request and zero-speed choice
   assign stop_req = servo_off_command || alarm_group_one || alarm_group_two
                  || s_reg.cut_expired;
   assign use_zero = alarm_group_two && !alarm_group_one
                  && !s_reg.group_two_alarm_stop_select
                  && (s_reg.ctrl_mode != MODE_TORQUE);

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      ev = '0;
      // Startup latch of stop settings
      if (!s_reg.started)
      begin
         s_next.started = 1'b1;
         s_next.stop_method_select = s_reg.stop_sel_wr;
         s_next.group_two_alarm_stop_select = s_reg.grp2_sel_wr;
      end
      // Power interruption timing
      if (!main_power_ok && !s_reg.cutting)
      begin
         s_next.cutting = 1'b1;
         s_next.cut_ms = 10'h000;
         ev[IRQ_CUT] = 1'b1;
      end
      else if (s_reg.cutting && main_power_ok)
      begin
         s_next.cutting = 1'b0;
      end
      else if (s_reg.cutting && tick && !s_reg.cut_expired)
      begin
         s_next.cut_ms = s_reg.cut_ms + 10'h001;
      end
      if (s_reg.cutting && !s_reg.cut_expired && s_reg.cut_ms >= s_reg.power_cut_hold_time)
      begin
         s_next.cut_expired = 1'b1;
         ev[IRQ_OFFPOW] = 1'b1;
      end
      // Stop sequencing
      unique case (s_reg.st)
         ST_RUN:
         begin
            if (stop_req)
            begin
               if (use_zero)
               begin
                  s_next.st = ST_ZSTOP;
               end
               else if (s_reg.stop_method_select == STOP_COAST)
               begin
                  s_next.st = ST_COAST;
               end
               else
               begin
                  s_next.st = ST_DB;
                  s_next.after_db_coast = (s_reg.stop_method_select == STOP_DB_COAST);
               end
            end
         end
         ST_ZSTOP:
         begin
            if (motor_stopped)
            begin
               s_next.st = (s_reg.stop_method_select == STOP_DB_HOLD) ? ST_DB : ST_COAST;
               s_next.after_db_coast = 1'b0;
               ev[IRQ_STOPPED] = 1'b1;
            end
         end
         ST_DB:
         begin
            if (motor_stopped && s_reg.after_db_coast)
            begin
               s_next.st = ST_COAST;
               ev[IRQ_STOPPED] = 1'b1;
            end
            else if (!stop_req && motor_stopped)
            begin
               s_next.st = ST_RUN;
            end
         end
         ST_COAST:
         begin
            if (!stop_req && motor_stopped)
            begin
               s_next.st = ST_RUN;
            end
         end
         default:
         begin
            s_next.st = ST_DB;
         end
      endcase
      if (!s_reg.cutting || main_power_ok)
      begin
         s_next.cut_expired = s_next.cut_expired && !main_power_ok;
      end
      // Register writes
      if (wr_en)
      begin
         unique case (paddr)
            CFG_OFF:
            begin
               s_next.stop_sel_wr = pwdata[CFG_STOP_LSB +: 2];
               s_next.grp2_sel_wr = pwdata[CFG_GRP2_BIT];
               s_next.ctrl_mode = pwdata[CFG_MODE_LSB +: 2];
            end
            HOLD_OFF:
            begin
               // Clamp into range, applied immediately
               if (pwdata[9:0] < HOLD_MIN || pwdata[31:10] != '0)
               begin
                  s_next.power_cut_hold_time = (pwdata[31:10] != '0) ? HOLD_MAX : HOLD_MIN;
               end
               else if (pwdata[9:0] > HOLD_MAX)
               begin
                  s_next.power_cut_hold_time = HOLD_MAX;
               end
               else
               begin
                  s_next.power_cut_hold_time = pwdata[9:0];
               end
            end
            IRQ_OFF:
            begin
               s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_W-1:0];
            end
            MASK_OFF:
            begin
               s_next.irq_mask = pwdata[IRQ_W-1:0];
            end
            CMD_OFF:
            begin
               // Restart re-latches the stop settings
               s_next.started = ~pwdata[0];
            end
            default:
            begin
               s_next.irq_mask = s_reg.irq_mask;
            end
         endcase
      end
      // Set wins over clear
      s_next.irq_stat = s_next.irq_stat | ev;
      // Read data captured in setup phase
      s_next.rdata = 32'h00000000;
      if (rd_en)
      begin
         if (paddr == CFG_OFF)
         begin
            s_next.rdata = {22'h000000, s_reg.ctrl_mode, 3'h0, s_reg.grp2_sel_wr,
                            2'h0, s_reg.stop_sel_wr};
         end
         else if (paddr == HOLD_OFF)
         begin
            s_next.rdata = {22'h000000, s_reg.power_cut_hold_time};
         end
         else if (paddr == STAT_OFF)
         begin
            s_next.rdata = {6'h00, s_reg.cut_ms, 4'h0, s_reg.st, 3'h0,
                            s_reg.group_two_alarm_stop_select, s_reg.stop_method_select,
                            s_reg.cut_expired, s_reg.cutting};
         end
         else if (paddr == IRQ_OFF)
         begin
            s_next.rdata = {29'h00000000, s_reg.irq_stat};
         end
         else if (paddr == MASK_OFF)
         begin
            s_next.rdata = {29'h00000000, s_reg.irq_mask};
         end
      end
   end

   // ----------------------------------------------------------
   // State register
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
         s_reg.power_cut_hold_time <= HOLD_RST;
         s_reg.st <= ST_RUN;
         s_reg.ctrl_mode <= MODE_POS;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign prdata = s_reg.rdata;
   assign motor_power_on = (s_reg.st == ST_RUN) || (s_reg.st == ST_ZSTOP);
   // No braking force once stopped or crawling
   assign dynamic_brake = (s_reg.st == ST_DB) && !motor_stopped && !low_speed;
   assign zero_speed_stop = (s_reg.st == ST_ZSTOP);
   assign power_cut_flag = s_reg.cutting;
   assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   chk_brake_no_force: assert property (@(posedge clk) disable iff (!nrst)
      (motor_stopped || low_speed) |-> !dynamic_brake)
      else $error("brake force at rest");
   chk_cut_flag: assert property (@(posedge clk) disable iff (!nrst)
      (!main_power_ok && !power_cut_flag) |=> power_cut_flag)
      else $error("cut not flagged");
   chk_hold_range: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.power_cut_hold_time >= HOLD_MIN && s_reg.power_cut_hold_time <= HOLD_MAX)
      else $error("hold time out of range");
   chk_short_cut_runs: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.cutting && s_reg.cut_ms < s_reg.power_cut_hold_time) |=> !$rose(s_reg.cut_expired))
      else $error("expired early");
   chk_count_stop: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.cutting && !tick && main_power_ok == 1'b0) |=> $stable(s_reg.cut_ms))
      else $error("count without tick");
   chk_zero_sel: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.st == ST_RUN && use_zero) |=> (s_reg.st == ST_ZSTOP))
      else $error("no zero-speed stop");
   chk_torque_ign: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.st == ST_RUN && alarm_group_two && s_reg.ctrl_mode == MODE_TORQUE)
      |=> (s_reg.st != ST_ZSTOP))
      else $error("torque zero stop");
   chk_coast_sel: assert property (@(posedge clk) disable iff (!nrst)
      (s_reg.st == ST_RUN && servo_off_command && !use_zero
       && s_reg.stop_method_select == STOP_COAST)
      |=> (s_reg.st == ST_COAST))
      else $error("coast not taken");
   chk_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.started |=> $stable(s_reg.stop_method_select))
      else $error("method changed live");
endmodule : stop_ctrl
`default_nettype wire

// ---- tb/host_model.sv ----
// Host controller and motor feedback model for the stop controller
`timescale 1ns/10ps
`default_nettype none
module host_model
(
   input wire logic clk,
   output logic servo_off_command,
   output logic alarm_group_one,
   output logic alarm_group_two,
   output logic main_power_ok,
   output logic motor_stopped,
   output logic low_speed
);
   // Idle: servo on, no alarm, power good, motor at rest
   initial
   begin
      servo_off_command = 1'b0;
      alarm_group_one = 1'b0;
      alarm_group_two = 1'b0;
      main_power_ok = 1'b1;
      motor_stopped = 1'b1;
      low_speed = 1'b1;
   end
   // Raise or drop a stop source: 0 servo off, 1 group one, 2 group two
   task send(input logic [1:0] src, input logic lvl);
      @(posedge clk);
      case (src)
         2'h0: servo_off_command <= lvl;
         2'h1: alarm_group_one <= lvl;
         default: alarm_group_two <= lvl;
      endcase
   endtask : send
   // Motor spinning fast or at rest
   task motion(input logic rest);
      @(posedge clk);
      motor_stopped <= rest;
      low_speed <= rest;
   endtask : motion
   // Motor turning at very low speed
   task crawl;
      @(posedge clk);
      motor_stopped <= 1'b0;
      low_speed <= 1'b1;
   endtask : crawl
   // Main circuit supply on or off
   task power(input logic ok);
      @(posedge clk);
      main_power_ok <= ok;
   endtask : power
endmodule : host_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the stop controller
`timescale 1ns/10ps
`default_nettype none
module tb;
   import stop_ctrl_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, irq, power_cut_flag;
   logic motor_power_on, dynamic_brake, zero_speed_stop;
   logic servo_off_command, alarm_group_one, alarm_group_two;
   logic main_power_ok, motor_stopped, low_speed;
   int mismatches = 0;
   int n_compared = 0;

   stop_ctrl uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .servo_off_command(servo_off_command),
      .alarm_group_one(alarm_group_one), .alarm_group_two(alarm_group_two),
      .main_power_ok(main_power_ok), .motor_stopped(motor_stopped),
      .low_speed(low_speed), .motor_power_on(motor_power_on),
      .dynamic_brake(dynamic_brake), .zero_speed_stop(zero_speed_stop),
      .power_cut_flag(power_cut_flag), .irq(irq));
   host_model host (.clk(clk), .servo_off_command(servo_off_command),
      .alarm_group_one(alarm_group_one), .alarm_group_two(alarm_group_two),
      .main_power_ok(main_power_ok), .motor_stopped(motor_stopped),
      .low_speed(low_speed));

   // 100 MHz clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   // Compare one value and count it
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; read data and error left in rd and err
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Poll the status state field until it shows st, then compare
   task wait_state(input logic [3:0] st);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, STAT_OFF, 32'h0);
         n++;
      end
      while (rd[11:8] !== st && n < 40);
      chk("state", {28'h0, st}, {28'h0, rd[11:8]});
   endtask : wait_state
   // Wait a bounded time for the power cut flag to reach lvl
   task wait_cut(input logic lvl);
      int n;
      n = 0;
      while (power_cut_flag !== lvl && n < 40)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_cut
   // Configure, restart, raise a stop source, follow the stop to rest and back
   task run_stop(input logic [1:0] src, input logic [1:0] m, input logic g2,
      input logic [1:0] mode, input logic [3:0] first, input logic [3:0] after);
      apb(1'b1, CFG_OFF, {22'h0, mode, 3'h0, g2, 2'h0, m});
      apb(1'b1, CMD_OFF, 32'h1);
      host.motion(1'b0);
      host.send(src, 1'b1);
      wait_state(first);
      chk("brake", {31'h0, first == ST_DB}, {31'h0, dynamic_brake});
      chk("zs_pwr", {30'h0, first == ST_ZSTOP, first == ST_ZSTOP},
         {30'h0, zero_speed_stop, motor_power_on});
      host.crawl;
      @(posedge clk);
      chk("brake_crawl", 32'h0, {31'h0, dynamic_brake});
      host.motion(1'b1);
      wait_state(after);
      chk("brake_rest", 32'h0, {31'h0, dynamic_brake});
      host.send(src, 1'b0);
      wait_state(ST_RUN);
   endtask : run_stop

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      wait_state(ST_RUN);
      apb(1'b0, HOLD_OFF, 32'h0);
      chk("hold_rst", {22'h0, HOLD_RST}, rd);
      chk("ready", 32'h1, {31'h0, pready});
      apb(1'b1, HOLD_OFF, 32'h5);
      apb(1'b0, HOLD_OFF, 32'h0);
      chk("hold_lo", {22'h0, HOLD_MIN}, rd);
      apb(1'b1, HOLD_OFF, 32'h7D0);
      apb(1'b0, HOLD_OFF, 32'h0);
      chk("hold_hi", {22'h0, HOLD_MAX}, rd);
      apb(1'b1, HOLD_OFF, 32'h14);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
   endtask : t_regs
   task t_servo_off;
      for (int i = 0; i < 3; i++)
         run_stop(2'h0, i[1:0], 1'b0, MODE_POS, i == 2 ? ST_COAST : ST_DB,
            i == 0 ? ST_DB : ST_COAST);
   endtask : t_servo_off
   task t_alarms;
      run_stop(2'h1, STOP_DB_COAST, 1'b0, MODE_SPEED, ST_DB, ST_COAST);
      run_stop(2'h2, STOP_DB_HOLD, 1'b0, MODE_POS, ST_ZSTOP, ST_DB);
      run_stop(2'h2, STOP_COAST, 1'b0, MODE_SPEED, ST_ZSTOP, ST_COAST);
      run_stop(2'h2, STOP_COAST, 1'b1, MODE_POS, ST_COAST, ST_COAST);
      run_stop(2'h2, STOP_DB_HOLD, 1'b1, MODE_SPEED, ST_DB, ST_DB);
      run_stop(2'h2, STOP_DB_COAST, 1'b0, MODE_TORQUE, ST_DB, ST_COAST);
   endtask : t_alarms
   task t_latch;
      apb(1'b1, CFG_OFF, 32'h2);
      apb(1'b0, STAT_OFF, 32'h0);
      chk("latched_old", 32'h1, {30'h0, rd[3:2]});
      apb(1'b1, CMD_OFF, 32'h1);
      apb(1'b0, STAT_OFF, 32'h0);
      chk("latched_new", 32'h2, {30'h0, rd[3:2]});
   endtask : t_latch
   task t_power;
      apb(1'b1, IRQ_OFF, 32'h7);
      host.power(1'b0);
      wait_cut(1'b1);
      chk("cut_flag", 32'h1, {31'h0, power_cut_flag});
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, MASK_OFF, 32'h1);
      @(posedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b0, STAT_OFF, 32'h0);
      chk("cut_stat", 32'h1, {20'h0, rd[25:16], rd[1:0]});
      host.power(1'b1);
      wait_cut(1'b0);
      chk("power_kept", 32'h1, {31'h0, motor_power_on});
      apb(1'b1, IRQ_OFF, 32'h1);
      apb(1'b0, IRQ_OFF, 32'h0);
      chk("irq_stat", 32'h0, rd);
      chk("irq_off", 32'h0, {31'h0, irq});
   endtask : t_power
   // Verdict and end of run
   task finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_servo_off;
      t_alarms;
      t_latch;
      t_power;
      finish_test;
   end
   // Watchdog against a hang
   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches++;
      finish_test;
   end
endmodule : tb
`default_nettype wire
